// File: src/cmt_pkg.sv
// Overview of operation
// - run bit 0 starts or holds counter
// - match or capture on A sets flag
// - flag clears by read one, write zero
// - clear source 001 clears on A event
// - edge field 00 counts falling edges
// - prescale 000 counts every module clock
// - buffer bit pairs registers A and C
// - op mode 0000 is normal counting
// - stop bit one halts, zero releases
// - halt bit 0 stops whole timer unit
// - counter is sixteen bit read write
// - match irq only when enable A set
package cmt_pkg;
    // register indices, byte address is four times the index
    localparam logic [23:0] IDX_HALT_CTRL_A = 24'hff_fdc8;
    localparam logic [23:0] IDX_START_CTRL = 24'hff_ffbc;
    localparam logic [23:0] IDX_COUNT_CTRL = 24'hff_ffc0;
    localparam logic [23:0] IDX_OP_SELECT = 24'hff_ffc1;
    localparam logic [23:0] IDX_IO_CTRL_HIGH = 24'hff_ffc2;
    localparam logic [23:0] IDX_IO_CTRL_LOW = 24'hff_ffc3;
    localparam logic [23:0] IDX_IRQ_ENABLE = 24'hff_ffc4;
    localparam logic [23:0] IDX_FLAG_REG = 24'hff_ffc5;
    localparam logic [23:0] IDX_TIMER_COUNT = 24'hff_ffc6;
    localparam logic [23:0] IDX_GENERAL_A = 24'hff_ffc8;
    localparam logic [23:0] IDX_GENERAL_C = 24'hff_ffcc;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 25;
    localparam int ADDR_MSB = 31;

    // single-bit field positions
    localparam int RUN_BIT_CH0 = 0;
    localparam int UNIT_HALT_BIT = 0;
    localparam int MATCH_FLAG_BIT = 0;
    localparam int IRQ_ENABLE_BIT = 0;
    localparam int CAPTURE_MODE_BIT = 3;

    // reset values and the count step
    localparam logic [15:0] HALT_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] GENERAL_RESET = 16'hffff;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    // field codes and prescaler constants
    localparam logic [2:0] CLR_NONE = 3'h0;
    localparam logic [2:0] CLR_ON_A = 3'h1;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [2:0] PS_DIV1 = 3'h0;
    localparam logic [2:0] PS_DIV4 = 3'h1;
    localparam logic [2:0] PS_DIV16 = 3'h2;
    localparam logic [2:0] PS_DIV64 = 3'h3;
    localparam logic [3:0] OP_NORMAL = 4'h0;
    localparam logic [5:0] MASK_DIV4 = 6'h03;
    localparam logic [5:0] MASK_DIV16 = 6'h0f;
    localparam logic [5:0] MASK_DIV64 = 6'h3f;
    localparam logic [5:0] DIV_ZERO = 6'h00;
    localparam logic [5:0] DIV_STEP = 6'h01;

    typedef struct packed {
        logic [2:0] clear_source_sel;
        logic [1:0] edge_sel;
        logic [2:0] prescale_sel;
    } cmt_count_ctrl_t;

    typedef struct packed {
        logic [2:0] spare;
        logic buffer_pair_a;
        logic [3:0] timer_op_select;
    } cmt_op_select_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_SEEN_ONE = 2'b01
    } cmt_clear_state_t;
endpackage

// File: src/cmt_channel.sv
module cmt_channel
    import cmt_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // capture pin and interrupt
    input wire logic CAPTURE_A_IN,
    output logic MATCH_IRQ_A
);
    // registers
    logic [15:0] halt_ctrl_a_q;
    logic [7:0] start_ctrl_q;
    cmt_count_ctrl_t count_ctrl_q;
    cmt_op_select_t op_select_q;
    logic [7:0] io_ctrl_high_q;
    logic [7:0] io_ctrl_low_q;
    logic [7:0] irq_enable_q;
    logic match_flag_a_q;
    logic [15:0] timer_count_q;
    logic [15:0] general_reg_a_q;
    logic [15:0] general_reg_c_q;
    cmt_clear_state_t clr_state_q;
    logic [5:0] div_q;
    logic cap_s1_q, cap_s2_q, cap_s3_q, cap_lvl_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q;

    // decoded strobes
    logic access, wr_en, rd_en, hit;
    logic [23:0] idx;
    logic halted, count_en, tick, capture_mode, cap_rise;
    logic match_ev, capt_ev, gra_ev, clr_ok;
    logic [5:0] mask;

    function automatic logic is_reg(input logic [23:0] a, input logic [23:0] r);
        return a == r;
    endfunction

    function automatic logic [5:0] prescale_mask(input logic [2:0] sel);
        unique case (sel)
            PS_DIV4: return MASK_DIV4;
            PS_DIV16: return MASK_DIV16;
            PS_DIV64: return MASK_DIV64;
            default: return DIV_ZERO;
        endcase
    endfunction

    // bus decode; high address bits must be clear for a hit
    assign idx = PADDR[IDX_MSB:IDX_LSB];
    assign hit = (PADDR[ADDR_MSB:IDX_MSB+1] == '0) && (PADDR[IDX_LSB-1:0] == '0) &&
                 (is_reg(idx, IDX_HALT_CTRL_A) || is_reg(idx, IDX_START_CTRL) ||
                  is_reg(idx, IDX_COUNT_CTRL) || is_reg(idx, IDX_OP_SELECT) ||
                  is_reg(idx, IDX_IO_CTRL_HIGH) || is_reg(idx, IDX_IO_CTRL_LOW) ||
                  is_reg(idx, IDX_IRQ_ENABLE) || is_reg(idx, IDX_FLAG_REG) ||
                  is_reg(idx, IDX_TIMER_COUNT) || is_reg(idx, IDX_GENERAL_A) ||
                  is_reg(idx, IDX_GENERAL_C));
    assign access = PSEL && PENABLE && pready_q;
    assign wr_en = access && PWRITE && !pslverr_q;
    assign rd_en = access && !PWRITE && !pslverr_q;

    // run gating; other op modes are not modelled so they hold the counter
    assign halted = halt_ctrl_a_q[UNIT_HALT_BIT];
    assign count_en = start_ctrl_q[RUN_BIT_CH0] && !halted &&
                      (op_select_q.timer_op_select == OP_NORMAL);
    assign mask = prescale_mask(count_ctrl_q.prescale_sel);

    // edge selection on the divided clock: wrap is its falling edge
    always_comb begin
        tick = 1'b0;
        if (mask == DIV_ZERO) begin
            tick = 1'b1;
        end else if (count_ctrl_q.edge_sel == EDGE_FALL) begin
            tick = (div_q & mask) == DIV_ZERO;
        end else if (count_ctrl_q.edge_sel == EDGE_RISE) begin
            tick = (div_q & mask) == ((mask >> 1) + DIV_STEP);
        end else begin
            tick = ((div_q & mask) == DIV_ZERO) ||
                   ((div_q & mask) == ((mask >> 1) + DIV_STEP));
        end
    end

    // events on general register A
    assign capture_mode = io_ctrl_low_q[CAPTURE_MODE_BIT];
    assign cap_rise = (cap_s2_q == cap_s3_q) && cap_s3_q && !cap_lvl_q;
    assign match_ev = count_en && tick && !capture_mode &&
                      (timer_count_q == general_reg_a_q);
    assign capt_ev = !halted && capture_mode && cap_rise;
    assign gra_ev = match_ev || capt_ev;
    assign clr_ok = wr_en && is_reg(idx, IDX_FLAG_REG) && !PWDATA[MATCH_FLAG_BIT] &&
                    (clr_state_q == RD_SEEN_ONE);

    // capture pin synchroniser; level accepted once stages two and three agree
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cap_s1_q <= 1'b0;
            cap_s2_q <= 1'b0;
            cap_s3_q <= 1'b0;
            cap_lvl_q <= 1'b0;
        end else begin
            cap_s1_q <= CAPTURE_A_IN;
            cap_s2_q <= cap_s1_q;
            cap_s3_q <= cap_s2_q;
            if (cap_s2_q == cap_s3_q) begin
                cap_lvl_q <= cap_s3_q;
            end
        end
    end

    // prescaler runs free unless the unit is halted
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            div_q <= DIV_ZERO;
        end else if (!halted) begin
            div_q <= div_q + DIV_STEP;
        end
    end

    // control registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            halt_ctrl_a_q <= HALT_RESET;
            start_ctrl_q <= BYTE_RESET;
            count_ctrl_q <= cmt_count_ctrl_t'(BYTE_RESET);
            op_select_q <= cmt_op_select_t'(BYTE_RESET);
            io_ctrl_high_q <= BYTE_RESET;
            io_ctrl_low_q <= BYTE_RESET;
            irq_enable_q <= BYTE_RESET;
        end else if (wr_en) begin
            if (is_reg(idx, IDX_HALT_CTRL_A)) halt_ctrl_a_q <= PWDATA[15:0];
            if (is_reg(idx, IDX_START_CTRL)) start_ctrl_q <= PWDATA[7:0];
            if (is_reg(idx, IDX_COUNT_CTRL)) count_ctrl_q <= cmt_count_ctrl_t'(PWDATA[7:0]);
            if (is_reg(idx, IDX_OP_SELECT)) op_select_q <= cmt_op_select_t'(PWDATA[7:0]);
            if (is_reg(idx, IDX_IO_CTRL_HIGH)) io_ctrl_high_q <= PWDATA[7:0];
            if (is_reg(idx, IDX_IO_CTRL_LOW)) io_ctrl_low_q <= PWDATA[7:0];
            if (is_reg(idx, IDX_IRQ_ENABLE)) irq_enable_q <= PWDATA[7:0];
        end
    end

    // counter; a software write beats counting in the same cycle
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            timer_count_q <= WORD_RESET;
        end else if (wr_en && is_reg(idx, IDX_TIMER_COUNT)) begin
            timer_count_q <= PWDATA[15:0];
        end else if (gra_ev && count_ctrl_q.clear_source_sel == CLR_ON_A) begin
            timer_count_q <= WORD_RESET;
        end else if (count_en && tick) begin
            timer_count_q <= timer_count_q + COUNT_STEP;
        end
    end

    // general registers A and C with buffer transfer
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            general_reg_a_q <= GENERAL_RESET;
            general_reg_c_q <= GENERAL_RESET;
        end else begin
            if (wr_en && is_reg(idx, IDX_GENERAL_A)) begin
                general_reg_a_q <= PWDATA[15:0];
            end else if (capt_ev) begin
                general_reg_a_q <= timer_count_q;
            end else if (match_ev && op_select_q.buffer_pair_a) begin
                general_reg_a_q <= general_reg_c_q;
            end
            if (wr_en && is_reg(idx, IDX_GENERAL_C)) begin
                general_reg_c_q <= PWDATA[15:0];
            end else if (capt_ev && op_select_q.buffer_pair_a) begin
                general_reg_c_q <= general_reg_a_q;
            end
        end
    end

    // flag: set wins over clear so no event is lost
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            match_flag_a_q <= 1'b0;
        end else if (gra_ev) begin
            match_flag_a_q <= 1'b1;
        end else if (clr_ok) begin
            match_flag_a_q <= 1'b0;
        end
    end

    // clear arming: a read that returned one arms the next write to the flag register, which clears only if it writes zero
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            clr_state_q <= RD_IDLE;
        end else begin
            unique case (clr_state_q)
                RD_IDLE: begin
                    if (rd_en && is_reg(idx, IDX_FLAG_REG) && prdata_q[MATCH_FLAG_BIT]) begin
                        clr_state_q <= RD_SEEN_ONE;
                    end
                end
                RD_SEEN_ONE: begin
                    if (wr_en && is_reg(idx, IDX_FLAG_REG)) begin
                        clr_state_q <= RD_IDLE;
                    end
                end
                default: clr_state_q <= RD_IDLE;
            endcase
        end
    end

    // apb answer prepared in setup, so the access phase has no wait state
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= PSEL && !PENABLE;
            pslverr_q <= PSEL && !PENABLE && !hit;
            prdata_q <= '0;
            if (PSEL && !PENABLE && !PWRITE) begin
                if (is_reg(idx, IDX_HALT_CTRL_A)) prdata_q <= {16'h0000, halt_ctrl_a_q};
                if (is_reg(idx, IDX_START_CTRL)) prdata_q <= {24'h00_0000, start_ctrl_q};
                if (is_reg(idx, IDX_COUNT_CTRL)) prdata_q <= {24'h00_0000, count_ctrl_q};
                if (is_reg(idx, IDX_OP_SELECT)) prdata_q <= {24'h00_0000, op_select_q};
                if (is_reg(idx, IDX_IO_CTRL_HIGH)) prdata_q <= {24'h00_0000, io_ctrl_high_q};
                if (is_reg(idx, IDX_IO_CTRL_LOW)) prdata_q <= {24'h00_0000, io_ctrl_low_q};
                if (is_reg(idx, IDX_IRQ_ENABLE)) prdata_q <= {24'h00_0000, irq_enable_q};
                if (is_reg(idx, IDX_FLAG_REG)) prdata_q <= {31'h0000_0000, match_flag_a_q};
                if (is_reg(idx, IDX_TIMER_COUNT)) prdata_q <= {16'h0000, timer_count_q};
                if (is_reg(idx, IDX_GENERAL_A)) prdata_q <= {16'h0000, general_reg_a_q};
                if (is_reg(idx, IDX_GENERAL_C)) prdata_q <= {16'h0000, general_reg_c_q};
            end
        end
    end

    // interrupt lags the flag by one cycle to come from a flop
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= match_flag_a_q && irq_enable_q[IRQ_ENABLE_BIT];
        end
    end

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign MATCH_IRQ_A = irq_q;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    logic cnt_wr;
    assign cnt_wr = wr_en && is_reg(idx, IDX_TIMER_COUNT);

    sequence s_flag_read_one;
        rd_en && is_reg(idx, IDX_FLAG_REG) && prdata_q[MATCH_FLAG_BIT];
    endsequence

    sequence s_zero_write;
        wr_en && is_reg(idx, IDX_FLAG_REG) && !PWDATA[MATCH_FLAG_BIT];
    endsequence

    a_stopped_count_hold: assert property (
        (!start_ctrl_q[RUN_BIT_CH0] && !cnt_wr && !gra_ev) |=> $stable(timer_count_q))
        else $error("counter moved while stopped");
    a_flag_on_event: assert property (
        gra_ev |=> match_flag_a_q)
        else $error("flag not set on register A event");
    a_flag_clear_arm: assert property (
        s_flag_read_one ##1 (!gra_ev && !wr_en)[*2] ##1 (s_zero_write and !gra_ev)
        |=> !match_flag_a_q)
        else $error("flag not cleared after read one write zero");
    a_flag_fall_cause: assert property (
        $fell(match_flag_a_q) |-> $past(clr_state_q == RD_SEEN_ONE && wr_en))
        else $error("flag cleared without read of one");
    a_clear_on_a: assert property (
        (gra_ev && count_ctrl_q.clear_source_sel == CLR_ON_A && !cnt_wr)
        |=> timer_count_q == WORD_RESET)
        else $error("counter not cleared on register A event");
    a_falling_edge_div4: assert property (
        (count_ctrl_q.edge_sel == EDGE_FALL && count_ctrl_q.prescale_sel == PS_DIV4 && tick)
        |-> (div_q[1:0] == 2'h0))
        else $error("tick off the falling edge");
    a_div1_every_cycle: assert property (
        (count_en && count_ctrl_q.prescale_sel == PS_DIV1 && !cnt_wr && !gra_ev)
        |=> timer_count_q == $past(timer_count_q) + COUNT_STEP)
        else $error("divide by one missed a cycle");
    a_buffer_transfer: assert property (
        (match_ev && op_select_q.buffer_pair_a && !(wr_en && is_reg(idx, IDX_GENERAL_A)))
        |=> general_reg_a_q == $past(general_reg_c_q))
        else $error("buffer transfer C to A missing");
    a_mode_gate: assert property (
        (op_select_q.timer_op_select != OP_NORMAL) |-> !match_ev)
        else $error("counting outside normal mode");
    a_halt_freeze: assert property (
        (halted && !cnt_wr) |=> ($stable(timer_count_q) && !$rose(match_flag_a_q)))
        else $error("activity during module stop");
    a_count_write: assert property (
        cnt_wr |=> timer_count_q == $past(PWDATA[15:0]))
        else $error("counter write lost");
    a_irq_gate: assert property (
        (!irq_enable_q[IRQ_ENABLE_BIT] ##1 !irq_enable_q[IRQ_ENABLE_BIT]) |-> !MATCH_IRQ_A)
        else $error("interrupt raised while disabled");
endmodule

// File: test/tb_top.sv
module tb_top import cmt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // bench side of the apb slave, capture pin and interrupt
    logic clk;
    logic rst_b;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cap_in;
    logic irq;
    logic [31:0] rd;
    logic [31:0] v;
    logic err;
    int n_errors;
    int num_checks;
    int cycles;

    cmt_channel cmt_channel_inst (
        .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .CAPTURE_A_IN(cap_in), .MATCH_IRQ_A(irq)
    );

    // 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one apb transfer; pready and data are taken at the rising edge itself
    task automatic apb(input logic wr, input logic [23:0] idx, input logic [31:0] wd);
        int w;
        w = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {6'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && w < 50) begin
            @(posedge clk);
            w++;
        end
        rd = prdata;
        err = pslverr;
        if (w >= 50) chk("pready", 32'h0000_0001, 32'h0000_0000);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [23:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input string name, input logic [23:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk(name, exp, rd);
    endtask

    // counter read must land inside a window of ticks
    task automatic cnt_rng(input int lo, input int hi);
        apb(1'b0, IDX_TIMER_COUNT, 32'h0000_0000);
        chk("count in window", 32'h0000_0001, {31'h0, (rd >= lo && rd <= hi)});
    endtask

    function automatic logic [31:0] ctrl_word(input logic [2:0] clr);
        cmt_count_ctrl_t c;
        c = '{clear_source_sel: clr, edge_sel: EDGE_FALL, prescale_sel: PS_DIV1};
        return {24'h00_0000, c};
    endfunction

    // hang guard, generous against roughly 560 cycles of tests
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        {psel, penable, pwrite, cap_in} = 4'h0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        rst_b = 1'b0;
        v = $urandom(51714);
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // reset values and an unmapped address
        rdchk("start", IDX_START_CTRL, 32'h0000_0000);
        rdchk("ctrl", IDX_COUNT_CTRL, 32'h0000_0000);
        rdchk("op", IDX_OP_SELECT, 32'h0000_0000);
        rdchk("halt", IDX_HALT_CTRL_A, 32'h0000_0000);
        rdchk("flag", IDX_FLAG_REG, 32'h0000_0000);
        rdchk("count", IDX_TIMER_COUNT, 32'h0000_0000);
        rdchk("gen a", IDX_GENERAL_A, 32'h0000_ffff);
        apb(1'b0, 24'h00_0001, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, err});
        $display("test reset done");
        // random read back, upper bits reserved
        for (int i = 0; i < 6; i++) begin
            v = $urandom;
            wr(IDX_COUNT_CTRL, v);
            rdchk("ctrl rb", IDX_COUNT_CTRL, v & 32'h0000_00ff);
            wr(IDX_OP_SELECT, v & 32'h0000_001f);
            rdchk("op rb", IDX_OP_SELECT, v & 32'h0000_001f);
            wr(IDX_TIMER_COUNT, v);
            rdchk("count rb", IDX_TIMER_COUNT, v & 32'h0000_ffff);
        end
        wr(IDX_COUNT_CTRL, ctrl_word(CLR_NONE));
        wr(IDX_OP_SELECT, {28'h000_0000, OP_NORMAL});
        $display("test readback done");
        // run bit gates counting at module clock / 1
        wr(IDX_TIMER_COUNT, 32'h0000_0000);
        wr(IDX_START_CTRL, 32'h0000_0001);
        repeat (40) @(posedge clk);
        wr(IDX_START_CTRL, 32'h0000_0000);
        cnt_rng(40, 46);
        v = rd;
        repeat (10) @(posedge clk);
        rdchk("stopped", IDX_TIMER_COUNT, v);
        // divide by four on the falling edge: about a quarter of the cycles
        wr(IDX_TIMER_COUNT, 32'h0000_0000);
        wr(IDX_COUNT_CTRL, {24'h00_0000, CLR_NONE, EDGE_FALL, PS_DIV4});
        wr(IDX_START_CTRL, 32'h0000_0001);
        repeat (40) @(posedge clk);
        wr(IDX_START_CTRL, 32'h0000_0000);
        cnt_rng(10, 12);
        $display("test run done");
        // compare match with clear on A, flag and interrupt
        wr(IDX_GENERAL_A, 32'h0000_0020);
        wr(IDX_COUNT_CTRL, ctrl_word(CLR_ON_A));
        wr(IDX_TIMER_COUNT, 32'h0000_0000);
        wr(IDX_START_CTRL, 32'h0000_0001);
        repeat (100) @(posedge clk);
        wr(IDX_START_CTRL, 32'h0000_0000);
        cnt_rng(0, 32);
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        wr(IDX_IRQ_ENABLE, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk("irq on", 32'h0000_0001, {31'h0, irq});
        wr(IDX_FLAG_REG, 32'h0000_0001);
        wr(IDX_FLAG_REG, 32'h0000_0000);
        rdchk("flag kept", IDX_FLAG_REG, 32'h0000_0001);
        wr(IDX_FLAG_REG, 32'h0000_0000);
        rdchk("flag cleared", IDX_FLAG_REG, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("irq off", 32'h0000_0000, {31'h0, irq});
        $display("test match done");
        // unit halt freezes the counter, release resumes it
        wr(IDX_TIMER_COUNT, 32'h0000_0000);
        wr(IDX_HALT_CTRL_A, 32'h0000_0001);
        wr(IDX_START_CTRL, 32'h0000_0001);
        repeat (20) @(posedge clk);
        rdchk("halted count", IDX_TIMER_COUNT, 32'h0000_0000);
        rdchk("halt rb", IDX_HALT_CTRL_A, 32'h0000_0001);
        wr(IDX_HALT_CTRL_A, 32'h0000_0000);
        repeat (20) @(posedge clk);
        cnt_rng(20, 28);
        wr(IDX_START_CTRL, 32'h0000_0000);
        $display("test halt done");
        // buffer pair: a match reloads A from C
        wr(IDX_OP_SELECT, 32'h0000_0010);
        wr(IDX_GENERAL_C, 32'h0000_0030);
        wr(IDX_GENERAL_A, 32'h0000_0010);
        wr(IDX_TIMER_COUNT, 32'h0000_0000);
        wr(IDX_START_CTRL, 32'h0000_0001);
        repeat (30) @(posedge clk);
        wr(IDX_START_CTRL, 32'h0000_0000);
        rdchk("gen a buffered", IDX_GENERAL_A, 32'h0000_0030);
        wr(IDX_OP_SELECT, 32'h0000_0000);
        rdchk("flag set", IDX_FLAG_REG, 32'h0000_0001);
        wr(IDX_FLAG_REG, 32'h0000_0000);
        $display("test buffer done");
        // input capture of a stopped random count into A
        v = {16'h0000, 16'($urandom)};
        wr(IDX_COUNT_CTRL, ctrl_word(CLR_NONE));
        wr(IDX_IO_CTRL_LOW, 32'h0000_0008);
        wr(IDX_TIMER_COUNT, v);
        @(posedge clk);
        cap_in <= 1'b1;
        repeat (8) @(posedge clk);
        cap_in <= 1'b0;
        repeat (8) @(posedge clk);
        rdchk("captured", IDX_GENERAL_A, v);
        rdchk("capture flag", IDX_FLAG_REG, 32'h0000_0001);
        $display("test capture done");
        results();
    end
endmodule
